/* rtl/dtc_pkg.sv */
// constants, types and register map of the dual timer/counter block
// assumes an AHB-Lite master reaching one word per register index
// Operation
// R1 - timer function counts system clocks after prescaler
// R2 - shared prescaler divides count rate by 1..16
// R3 - counter function samples input, counts high-then-low
// R4 - counted value appears cycle after edge detect
// R5 - source holds each input level one clock
// R6 - port-bit count inputs on pinless variant
// R7 - function-select bit and two-bit mode field
// R8 - mode 0: 8-bit counter behind 1..8-bit prescaler
// R9 - mode 0 rollover sets overflow flag
// R10 - count only when run and gate allows
// R11 - 13-bit count uses high byte, low 5 bits
// R12 - setting run leaves count registers alone
// R13 - mode 0 period 256 x 2^(psc+1) x (tps+1)
// R14 - gate bits: mode bit 7 timer1, bit 3 timer0
// R15 - gate pins usable only with RC oscillator
// R16 - mode 1: 16-bit count, reload and flag on wrap
// R17 - reload registers reset to zero
// R18 - mode 1 period (65536 - reload) x (tps+1)
// R19 - mode 2: low byte reloads from high byte
// R20 - mode 2 period (256 - high) x (tps+1)
// R21 - reload registers plain storage in modes 0, 2
// R22 - mode 3: timer1 holds, timer0 splits in two
// R23 - overflow flag cleared on interrupt vector
// R24 - control register B resets to 24h
// R25 - flag set and reload in overflow cycle
package dtc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] TIMER_CONTROL_IDX = 8'h88;
  localparam logic [7:0] TIMER_MODE_IDX = 8'h89;
  localparam logic [7:0] T0_COUNT_LOW_IDX = 8'h8a;
  localparam logic [7:0] T1_COUNT_LOW_IDX = 8'h8b;
  localparam logic [7:0] T0_COUNT_HIGH_IDX = 8'h8c;
  localparam logic [7:0] T1_COUNT_HIGH_IDX = 8'h8d;
  localparam logic [7:0] TIMER_CONTROL_B_IDX = 8'h91;
  localparam logic [7:0] T0_RELOAD_LOW_IDX = 8'h92;
  localparam logic [7:0] T1_RELOAD_LOW_IDX = 8'h93;
  localparam logic [7:0] T0_RELOAD_HIGH_IDX = 8'h94;
  localparam logic [7:0] T1_RELOAD_HIGH_IDX = 8'h95;
  localparam logic [7:0] SYS_PRESCALE_IDX = 8'h96;
  localparam logic [7:0] CONFIG_IDX = 8'h97;
  localparam int ADDR_IDX_LSB = 2;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // control register bits and mode register nibble fields
  localparam int T1_OVF_BIT = 7;
  localparam int T1_RUN_BIT = 6;
  localparam int T0_OVF_BIT = 5;
  localparam int T0_RUN_BIT = 4;
  localparam int T1_CTL_LSB = 4;
  localparam int T0_CTL_LSB = 0;
  localparam int CTL_W = 4;

  // control register B prescale fields
  localparam int PSC1_LSB = 3;
  localparam int PRESCALE_WIDTH_FIELD_LSB = 0;
  localparam int PSC_W = 3;
  localparam int TPS_W = 4;

  // configuration register bits
  localparam int CFG_PORT_SRC_BIT = 0;
  localparam int CFG_RC_OSC_BIT = 1;
  localparam int CFG_PORT_T0_BIT = 2;
  localparam int CFG_PORT_T1_BIT = 3;

  // reset values and byte constants
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] CONTROL_B_RESET = 8'h24;
  localparam logic [7:0] CONFIG_RESET = 8'h02;
  localparam logic [7:0] MODE0_FULL_SHIFT = 8'h07;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  typedef enum logic [1:0] {
    MODE_VARIABLE = 2'h0,
    MODE_RELOAD16 = 2'h1,
    MODE_RELOAD8 = 2'h2,
    MODE_SPLIT = 2'h3
  } dtc_mode_e;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_RD_WAIT = 3'h2,
    BUS_RD_DONE = 3'h4
  } dtc_bus_e;

  // one timer nibble of the mode register
  typedef struct packed {
    logic gate;
    logic counter_sel;
    dtc_mode_e mode;
  } dtc_tmr_ctl_s;

  // next count of one timer
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic ovf;
  } dtc_cnt_s;

endpackage

/* rtl/dtc_top.sv */
// dual 16-bit timer/counter with its register file on AHB-Lite
// assumes count and gate inputs synchronous to CORE_CLK_I, single word transfers
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dtc_top #(
  parameter int ADDR_W = 12
) (
  input wire logic CORE_CLK_I, // system clock, 200 MHz
  input wire logic RST_I, // async reset, active high
  input wire logic CE_I, // clock enable, freezes all state when low
  input wire logic HSEL_I, // ahb slave select
  input wire logic [ADDR_W-1:0] HADDR_I, // ahb byte address
  input wire logic [1:0] HTRANS_I, // ahb transfer type
  input wire logic HWRITE_I, // ahb write
  input wire logic [2:0] HSIZE_I, // ahb size, word only
  input wire logic [31:0] HWDATA_I, // ahb write data
  input wire logic HREADY_I, // ahb bus ready
  output logic [31:0] HRDATA_O, // ahb read data
  output logic HREADYOUT_O, // ahb slave ready
  output logic HRESP_O, // ahb response, always okay
  input wire logic COUNT_INPUT0_I, // timer0 external count input
  input wire logic COUNT_INPUT1_I, // timer1 external count input
  input wire logic EXT_IRQ0_PIN_I, // timer0 gate pin
  input wire logic EXT_IRQ1_PIN_I, // timer1 gate pin
  input wire logic TIMER0_VECTOR_ACK_I, // pulse: cpu vectored to timer0 routine
  input wire logic TIMER1_VECTOR_ACK_I, // pulse: cpu vectored to timer1 routine
  output logic TIMER0_OVERFLOW_FLAG_O, // timer0 overflow flag
  output logic TIMER1_OVERFLOW_FLAG_O // timer1 overflow flag
);

  // one increment step of a timer in the given mode
  function automatic dtc_pkg::dtc_cnt_s step(input dtc_pkg::dtc_mode_e mode, input logic [2:0] psc,
                                            input logic [7:0] lo, input logic [7:0] hi,
                                            input logic [7:0] rlo, input logic [7:0] rhi);
    dtc_pkg::dtc_cnt_s r;
    logic [7:0] mask;
    r = '{high: hi, low: lo, ovf: 1'h0};
    mask = dtc_pkg::BYTE_ONES >> (dtc_pkg::MODE0_FULL_SHIFT[2:0] - psc); // R8
    case (mode)
      dtc_pkg::MODE_VARIABLE: begin
        // low bits act as prescaler, bits above it keep what software wrote
        if ((lo & mask) == mask) begin // R11
          r.low = lo & ~mask;
          r.high = hi + dtc_pkg::BYTE_ONE;
          r.ovf = (hi == dtc_pkg::BYTE_ONES); // R9 R13
        end else begin
          r.low = lo + dtc_pkg::BYTE_ONE;
        end
      end
      dtc_pkg::MODE_RELOAD16: begin
        if ({hi, lo} == {dtc_pkg::BYTE_ONES, dtc_pkg::BYTE_ONES}) begin
          r.high = rhi; // R16 R18
          r.low = rlo;
          r.ovf = 1'h1;
        end else begin
          {r.high, r.low} = {hi, lo} + {dtc_pkg::BYTE_ZERO, dtc_pkg::BYTE_ONE};
        end
      end
      dtc_pkg::MODE_RELOAD8: begin
        if (lo == dtc_pkg::BYTE_ONES) begin
          r.low = hi; // R19 R20
          r.ovf = 1'h1;
        end else begin
          r.low = lo + dtc_pkg::BYTE_ONE;
        end
      end
      default: begin
        // split low half: free 8-bit wrap
        r.low = lo + dtc_pkg::BYTE_ONE;
        r.ovf = (lo == dtc_pkg::BYTE_ONES);
      end
    endcase
    return r;
  endfunction

  logic [7:0] control_reg, timer_mode_reg, timer_control_b_reg, config_reg;
  logic [dtc_pkg::TPS_W-1:0] system_timer_prescale_reg, psc_cnt_reg;
  logic [7:0] timer0_count_low_reg, timer0_count_high_reg, timer1_count_low_reg, timer1_count_high_reg;
  logic [7:0] timer0_reload_low_reg, timer0_reload_high_reg, timer1_reload_low_reg, timer1_reload_high_reg;
  logic samp0_reg, prev0_reg, samp1_reg, prev1_reg;
  dtc_pkg::dtc_bus_e bus_state_reg;
  logic wr_pend_reg;
  logic [7:0] idx_reg;
  logic [31:0] rdata_reg;

  // bus address phase
  logic accept;
  logic [7:0] haddr_idx;
  assign accept = HSEL_I & HTRANS_I[dtc_pkg::HTRANS_ACTIVE_BIT] & HREADY_I;
  assign haddr_idx = HADDR_I[dtc_pkg::ADDR_IDX_LSB +: 8];
  assign HREADYOUT_O = (bus_state_reg != dtc_pkg::BUS_RD_WAIT);
  assign HRESP_O = 1'h0;
  assign HRDATA_O = rdata_reg;

  // reads take one wait state so read-after-write always sees the new value
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bus_state_reg <= dtc_pkg::BUS_IDLE;
      wr_pend_reg <= 1'h0;
      idx_reg <= dtc_pkg::BYTE_ZERO;
    end else if (CE_I) begin
      wr_pend_reg <= accept & HWRITE_I;
      if (accept) begin
        idx_reg <= haddr_idx;
      end
      case (bus_state_reg)
        dtc_pkg::BUS_RD_WAIT: begin
          bus_state_reg <= dtc_pkg::BUS_RD_DONE;
        end
        dtc_pkg::BUS_IDLE, dtc_pkg::BUS_RD_DONE: begin
          bus_state_reg <= (accept & ~HWRITE_I & (HSIZE_I != 3'h7)) ? dtc_pkg::BUS_RD_WAIT : dtc_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_reg <= dtc_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // write strobe for one register index
  function automatic logic wr_hit(input logic pend, input logic [7:0] idx, input logic [7:0] want);
    return pend & (idx == want);
  endfunction

  logic [7:0] wdata;
  assign wdata = HWDATA_I[7:0];

  // decoded controls
  dtc_pkg::dtc_tmr_ctl_s ctl0, ctl1;
  logic [2:0] prescale_width_field, psc1;
  logic tr0, tr1, rc_osc, gate_lvl0, gate_lvl1, src0, src1;
  assign ctl0 = timer_mode_reg[dtc_pkg::T0_CTL_LSB +: dtc_pkg::CTL_W]; // R7 R14
  assign ctl1 = timer_mode_reg[dtc_pkg::T1_CTL_LSB +: dtc_pkg::CTL_W]; // R7 R14
  assign prescale_width_field = timer_control_b_reg[dtc_pkg::PRESCALE_WIDTH_FIELD_LSB +: dtc_pkg::PSC_W];
  assign psc1 = timer_control_b_reg[dtc_pkg::PSC1_LSB +: dtc_pkg::PSC_W];
  assign tr0 = control_reg[dtc_pkg::T0_RUN_BIT];
  assign tr1 = control_reg[dtc_pkg::T1_RUN_BIT];
  assign rc_osc = config_reg[dtc_pkg::CFG_RC_OSC_BIT];
  // pins belong to the crystal otherwise, then the gate reads as open
  assign gate_lvl0 = rc_osc ? EXT_IRQ0_PIN_I : 1'h1; // R15
  assign gate_lvl1 = rc_osc ? EXT_IRQ1_PIN_I : 1'h1; // R15
  // pinless variant drives count inputs from port bits
  assign src0 = config_reg[dtc_pkg::CFG_PORT_SRC_BIT] ? config_reg[dtc_pkg::CFG_PORT_T0_BIT] : COUNT_INPUT0_I; // R6
  assign src1 = config_reg[dtc_pkg::CFG_PORT_SRC_BIT] ? config_reg[dtc_pkg::CFG_PORT_T1_BIT] : COUNT_INPUT1_I; // R6

  // shared prescaler: tick once per tps+1 clocks
  logic tick;
  assign tick = (psc_cnt_reg == system_timer_prescale_reg); // R2
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      psc_cnt_reg <= '0;
    end else if (CE_I) begin
      psc_cnt_reg <= tick ? '0 : psc_cnt_reg + 4'h1; // R2
    end
  end

  // count input samples; needs each level held a clock by the source
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      samp0_reg <= 1'h0;
      prev0_reg <= 1'h0;
      samp1_reg <= 1'h0;
      prev1_reg <= 1'h0;
    end else if (CE_I) begin
      samp0_reg <= src0; // R3 R5
      prev0_reg <= samp0_reg;
      samp1_reg <= src1; // R3 R5
      prev1_reg <= samp1_reg;
    end
  end

  // count events and enables
  logic edge0, edge1, split0, allow0, allow1, inc0, inc1, inc_th0;
  assign edge0 = prev0_reg & ~samp0_reg; // R3
  assign edge1 = prev1_reg & ~samp1_reg; // R3
  assign split0 = (ctl0.mode == dtc_pkg::MODE_SPLIT);
  assign allow0 = tr0 & (~ctl0.gate | gate_lvl0); // R10
  assign allow1 = tr1 & (~ctl1.gate | gate_lvl1) & (ctl1.mode != dtc_pkg::MODE_SPLIT); // R10 R22
  assign inc0 = allow0 & (ctl0.counter_sel ? edge0 : tick); // R1 R4
  assign inc1 = allow1 & (ctl1.counter_sel ? edge1 : tick); // R1 R4
  assign inc_th0 = split0 & tr1 & tick; // R22

  // next counts; split mode hands timer1's run and flag to timer0 high byte
  dtc_pkg::dtc_cnt_s c0, c1;
  logic set0, set1, ovf_h0;
  always_comb begin
    c0 = '{high: timer0_count_high_reg, low: timer0_count_low_reg, ovf: 1'h0};
    c1 = '{high: timer1_count_high_reg, low: timer1_count_low_reg, ovf: 1'h0};
    ovf_h0 = 1'h0;
    if (inc0) begin
      c0 = step(ctl0.mode, prescale_width_field, timer0_count_low_reg, timer0_count_high_reg,
                timer0_reload_low_reg, timer0_reload_high_reg);
    end
    if (inc1) begin
      c1 = step(ctl1.mode, psc1, timer1_count_low_reg, timer1_count_high_reg,
                timer1_reload_low_reg, timer1_reload_high_reg);
    end
    if (split0) begin
      c0.high = timer0_count_high_reg + {7'h0, inc_th0}; // R22
      ovf_h0 = inc_th0 & (timer0_count_high_reg == dtc_pkg::BYTE_ONES);
    end
  end
  assign set0 = c0.ovf;
  assign set1 = split0 ? ovf_h0 : c1.ovf; // R22

  // count registers; a software write to a byte wins over counting
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      timer0_count_low_reg <= dtc_pkg::BYTE_ZERO;
      timer0_count_high_reg <= dtc_pkg::BYTE_ZERO;
      timer1_count_low_reg <= dtc_pkg::BYTE_ZERO;
      timer1_count_high_reg <= dtc_pkg::BYTE_ZERO;
    end else if (CE_I) begin
      timer0_count_low_reg <= wr_hit(wr_pend_reg, idx_reg, dtc_pkg::T0_COUNT_LOW_IDX) ? wdata : c0.low; // R25
      timer0_count_high_reg <= wr_hit(wr_pend_reg, idx_reg, dtc_pkg::T0_COUNT_HIGH_IDX) ? wdata : c0.high;
      timer1_count_low_reg <= wr_hit(wr_pend_reg, idx_reg, dtc_pkg::T1_COUNT_LOW_IDX) ? wdata : c1.low; // R25
      timer1_count_high_reg <= wr_hit(wr_pend_reg, idx_reg, dtc_pkg::T1_COUNT_HIGH_IDX) ? wdata : c1.high;
    end
  end

  // control register: run bits from software, flags set by overflow
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      control_reg <= dtc_pkg::BYTE_ZERO;
    end else if (CE_I) begin
      if (wr_hit(wr_pend_reg, idx_reg, dtc_pkg::TIMER_CONTROL_IDX)) begin
        control_reg[dtc_pkg::T0_RUN_BIT] <= wdata[dtc_pkg::T0_RUN_BIT]; // R12
        control_reg[dtc_pkg::T1_RUN_BIT] <= wdata[dtc_pkg::T1_RUN_BIT];
        control_reg[dtc_pkg::T0_OVF_BIT] <= set0 | wdata[dtc_pkg::T0_OVF_BIT];
        control_reg[dtc_pkg::T1_OVF_BIT] <= set1 | wdata[dtc_pkg::T1_OVF_BIT];
      end else begin
        // set wins over the vector clear in the same cycle
        control_reg[dtc_pkg::T0_OVF_BIT] <= set0 | (control_reg[dtc_pkg::T0_OVF_BIT] & ~TIMER0_VECTOR_ACK_I); // R23 R25
        control_reg[dtc_pkg::T1_OVF_BIT] <= set1 | (control_reg[dtc_pkg::T1_OVF_BIT] & ~TIMER1_VECTOR_ACK_I); // R23 R25
      end
    end
  end
  assign TIMER0_OVERFLOW_FLAG_O = control_reg[dtc_pkg::T0_OVF_BIT];
  assign TIMER1_OVERFLOW_FLAG_O = control_reg[dtc_pkg::T1_OVF_BIT];

  // configuration and reload registers, plain storage for software
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      timer_mode_reg <= dtc_pkg::BYTE_ZERO;
      timer_control_b_reg <= dtc_pkg::CONTROL_B_RESET; // R24
      config_reg <= dtc_pkg::CONFIG_RESET;
      system_timer_prescale_reg <= '0;
      timer0_reload_low_reg <= dtc_pkg::BYTE_ZERO; // R17
      timer0_reload_high_reg <= dtc_pkg::BYTE_ZERO;
      timer1_reload_low_reg <= dtc_pkg::BYTE_ZERO;
      timer1_reload_high_reg <= dtc_pkg::BYTE_ZERO;
    end else if (CE_I && wr_pend_reg) begin
      case (idx_reg)
        dtc_pkg::TIMER_MODE_IDX: timer_mode_reg <= wdata;
        dtc_pkg::TIMER_CONTROL_B_IDX: timer_control_b_reg <= wdata;
        dtc_pkg::CONFIG_IDX: config_reg <= {4'h0, wdata[3:0]};
        dtc_pkg::SYS_PRESCALE_IDX: system_timer_prescale_reg <= wdata[dtc_pkg::TPS_W-1:0];
        dtc_pkg::T0_RELOAD_LOW_IDX: timer0_reload_low_reg <= wdata; // R21
        dtc_pkg::T0_RELOAD_HIGH_IDX: timer0_reload_high_reg <= wdata;
        dtc_pkg::T1_RELOAD_LOW_IDX: timer1_reload_low_reg <= wdata; // R21
        dtc_pkg::T1_RELOAD_HIGH_IDX: timer1_reload_high_reg <= wdata;
        default: begin
        end
      endcase
    end
  end

  // read data, loaded in the wait state; unmapped reads give zero
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_reg <= '0;
    end else if (CE_I && bus_state_reg == dtc_pkg::BUS_RD_WAIT) begin
      case (idx_reg)
        dtc_pkg::TIMER_CONTROL_IDX: rdata_reg <= {24'h0, control_reg};
        dtc_pkg::TIMER_MODE_IDX: rdata_reg <= {24'h0, timer_mode_reg};
        dtc_pkg::T0_COUNT_LOW_IDX: rdata_reg <= {24'h0, timer0_count_low_reg};
        dtc_pkg::T1_COUNT_LOW_IDX: rdata_reg <= {24'h0, timer1_count_low_reg};
        dtc_pkg::T0_COUNT_HIGH_IDX: rdata_reg <= {24'h0, timer0_count_high_reg};
        dtc_pkg::T1_COUNT_HIGH_IDX: rdata_reg <= {24'h0, timer1_count_high_reg};
        dtc_pkg::TIMER_CONTROL_B_IDX: rdata_reg <= {24'h0, timer_control_b_reg};
        dtc_pkg::T0_RELOAD_LOW_IDX: rdata_reg <= {24'h0, timer0_reload_low_reg};
        dtc_pkg::T1_RELOAD_LOW_IDX: rdata_reg <= {24'h0, timer1_reload_low_reg};
        dtc_pkg::T0_RELOAD_HIGH_IDX: rdata_reg <= {24'h0, timer0_reload_high_reg};
        dtc_pkg::T1_RELOAD_HIGH_IDX: rdata_reg <= {24'h0, timer1_reload_high_reg};
        dtc_pkg::SYS_PRESCALE_IDX: rdata_reg <= {28'h0, system_timer_prescale_reg};
        dtc_pkg::CONFIG_IDX: rdata_reg <= {24'h0, config_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end

  // checks on the counting behaviour
  logic [15:0] word0, word1;
  assign word0 = {timer0_count_high_reg, timer0_count_low_reg};
  assign word1 = {timer1_count_high_reg, timer1_count_low_reg};

  a_overflow_sets_flag: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R9
    CE_I && set0 |=> TIMER0_OVERFLOW_FLAG_O)
    else $error("timer0 overflow did not set its flag");

  a_mode1_reload_value: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R16
    CE_I && !wr_pend_reg && inc1 && ctl1.mode == dtc_pkg::MODE_RELOAD16 && !split0 && word1 == 16'hffff
    |=> word1 == {$past(timer1_reload_high_reg), $past(timer1_reload_low_reg)} && TIMER1_OVERFLOW_FLAG_O)
    else $error("mode 1 wrap did not reload and flag");

  a_mode2_high_kept: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R19
    CE_I && !wr_pend_reg && inc0 && ctl0.mode == dtc_pkg::MODE_RELOAD8
    |=> timer0_count_high_reg == $past(timer0_count_high_reg))
    else $error("mode 2 changed the high byte");

  a_run_off_hold: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R10
    CE_I && !wr_pend_reg && !tr1 ##1 CE_I && !wr_pend_reg |=> word1 == $past(word1, 2))
    else $error("timer1 counted while stopped");

  a_prescale_wrap: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R2
    CE_I && tick |=> psc_cnt_reg == '0)
    else $error("prescaler did not restart after tick");

  a_edge_counts_once: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R4
    CE_I && !wr_pend_reg && allow1 && ctl1.counter_sel && ctl1.mode == dtc_pkg::MODE_RELOAD16
    && edge1 && word1 != 16'hffff |=> word1 == $past(word1) + 16'h0001)
    else $error("falling edge not counted in the next cycle");

  a_split_t1_hold: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R22
    CE_I && !wr_pend_reg && ctl1.mode == dtc_pkg::MODE_SPLIT |=> word1 == $past(word1))
    else $error("timer1 moved in mode 3");

  a_vector_clears: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R23
    CE_I && TIMER1_VECTOR_ACK_I && !set1 && !wr_pend_reg |=> !TIMER1_OVERFLOW_FLAG_O)
    else $error("vector acknowledge did not clear timer1 flag");

  a_same_cycle_set: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // R25
    CE_I && set1 && TIMER1_VECTOR_ACK_I |=> TIMER1_OVERFLOW_FLAG_O)
    else $error("flag set lost against clear");

endmodule
`default_nettype wire

/* verif/dtc_pulse_src.sv */
// partner model: external count pulse source and gate pin of one timer
// assumes the bench calls its tasks from its own clocked sequence
`timescale 1ns/1ps
`default_nettype none
module dtc_pulse_src (
  input wire logic clk_i, // system clock
  output logic count_o, // count input level
  output logic gate_o // gate pin level
);
  // both lines are driven levels at all times, idle high count, closed gate
  initial begin
    count_o = 1'b1;
    gate_o = 1'b0;
  end
  // n falling edges, every level held hold cycles so each one is sampled
  task automatic pulses(input int n, input int hold);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk_i);
      count_o <= ~count_o;
      repeat ((hold < 1 ? 1 : hold) - 1) @(posedge clk_i);
    end
  endtask
  // gate level changes just after an edge
  task automatic set_gate(input logic lvl);
    @(posedge clk_i);
    gate_o <= lvl;
  endtask
endmodule
`default_nettype wire

/* verif/dtc_top_bench.sv */
// self-checking bench of the dual timer/counter over its ahb-lite registers
// assumes one word per register index and one partner per timer input
`timescale 1ns/1ps
`default_nettype none
module dtc_top_bench;
  logic clk, rst, hsel, hwrite, ack0, ack1, hrdy, hresp, c0, c1, g0, g1, f0, f1;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  dtc_top dtc_top_inst (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hrdy),
    .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .COUNT_INPUT0_I(c0), .COUNT_INPUT1_I(c1),
    .EXT_IRQ0_PIN_I(g0), .EXT_IRQ1_PIN_I(g1), .TIMER0_VECTOR_ACK_I(ack0), .TIMER1_VECTOR_ACK_I(ack1),
    .TIMER0_OVERFLOW_FLAG_O(f0), .TIMER1_OVERFLOW_FLAG_O(f1));
  dtc_pulse_src src0_inst (.clk_i(clk), .count_o(c0), .gate_o(g0));
  dtc_pulse_src src1_inst (.clk_i(clk), .count_o(c1), .gate_o(g1));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, the whole run needs a few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] t=%0t run did not finish", $time);
      end_sim();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one single word transfer, held until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {2'h0, idx, 2'h0};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    bus(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp}, what);
    check({31'h0, hresp}, 32'h0, "okay response");
  endtask
  function automatic logic flag(input logic t1);
    return t1 ? f1 : f0;
  endfunction
  // cycles between two overflows; the first flag is cleared by a vector ack
  task automatic period(input logic t1, input int exp, input string what);
    int k;
    // drop a flag left from earlier overflows so the first rise is a fresh one
    if (t1) ack1 <= 1'b1;
    else ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (flag(t1) !== 1'b1 && k < 3000);
    if (t1) ack1 <= 1'b1;
    else ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    n = 1;
    do begin
      @(posedge clk);
      n++;
    end while (flag(t1) !== 1'b1 && n < 3000);
    check(32'(n), 32'(exp), what);
  endtask
  task automatic t_reset();
    rchk(dtc_pkg::TIMER_CONTROL_B_IDX, 8'h24, "ctlb reset");
    for (int i = 0; i < 4; i++) begin
      rchk(dtc_pkg::T0_RELOAD_LOW_IDX + 8'(i), 8'h00, "reload reset");
      bus(1'b1, dtc_pkg::T0_RELOAD_LOW_IDX + 8'(i), 8'ha0 + 8'(i));
      rchk(dtc_pkg::T0_RELOAD_LOW_IDX + 8'(i), 8'ha0 + 8'(i), "reload storage");
    end
    rchk(8'h90, 8'h00, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_mode2();
    logic [7:0] system_timer_prescale [2] = '{8'h00, 8'h0f};
    bus(1'b1, dtc_pkg::T0_COUNT_HIGH_IDX, 8'hfc);
    bus(1'b1, dtc_pkg::TIMER_MODE_IDX, 8'h02);
    foreach (system_timer_prescale[i]) begin
      bus(1'b1, dtc_pkg::SYS_PRESCALE_IDX, system_timer_prescale[i]);
      bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h10);
      period(1'b0, 4 * (int'(system_timer_prescale[i]) + 1), "mode2 period");
    end
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h00);
    rchk(dtc_pkg::T0_COUNT_HIGH_IDX, 8'hfc, "mode2 high kept");
    $display("test mode2 done");
  endtask
  // timer1 in mode 1 with reload fff0h, then mode 0 with that reload ignored
  task automatic t_mode10();
    bus(1'b1, dtc_pkg::SYS_PRESCALE_IDX, 8'h00);
    bus(1'b1, dtc_pkg::T1_RELOAD_HIGH_IDX, 8'hff);
    bus(1'b1, dtc_pkg::T1_RELOAD_LOW_IDX, 8'hf0);
    bus(1'b1, dtc_pkg::T1_COUNT_HIGH_IDX, 8'hff);
    bus(1'b1, dtc_pkg::T1_COUNT_LOW_IDX, 8'hf0);
    bus(1'b1, dtc_pkg::TIMER_MODE_IDX, 8'h10);
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h40);
    period(1'b1, 16, "mode1 period");
    bus(1'b1, dtc_pkg::TIMER_MODE_IDX, 8'h00);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, dtc_pkg::TIMER_CONTROL_B_IDX, 8'h04 + 8'(p << 3));
      period(1'b1, 256 << (p + 1), "mode0 period");
    end
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h00);
    $display("test mode1 mode0 done");
  endtask
  // timer1 counts falling edges from its pin, then from the config bit
  task automatic t_counter();
    bus(1'b1, dtc_pkg::T1_COUNT_LOW_IDX, 8'h00);
    bus(1'b1, dtc_pkg::TIMER_MODE_IDX, 8'h50);
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h40);
    src1_inst.pulses(5, 1);
    repeat (3) @(posedge clk);
    rchk(dtc_pkg::T1_COUNT_LOW_IDX, 8'h05, "fast edges");
    src1_inst.pulses(3, 4);
    repeat (3) @(posedge clk);
    rchk(dtc_pkg::T1_COUNT_LOW_IDX, 8'h08, "slow edges");
    bus(1'b1, dtc_pkg::CONFIG_IDX, 8'h0b);
    bus(1'b1, dtc_pkg::CONFIG_IDX, 8'h03);
    repeat (3) @(posedge clk);
    rchk(dtc_pkg::T1_COUNT_LOW_IDX, 8'h09, "port bit edge");
    bus(1'b1, dtc_pkg::CONFIG_IDX, 8'h02);
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h00);
    $display("test counter done");
  endtask
  // timer0 gated by its pin, then the pin ignored without the rc oscillator
  task automatic t_gate();
    bus(1'b1, dtc_pkg::T0_COUNT_LOW_IDX, 8'h10);
    bus(1'b1, dtc_pkg::T0_COUNT_HIGH_IDX, 8'h00);
    bus(1'b1, dtc_pkg::TIMER_MODE_IDX, 8'h09);
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h10);
    repeat (20) @(posedge clk);
    rchk(dtc_pkg::T0_COUNT_LOW_IDX, 8'h10, "gate closed");
    src0_inst.set_gate(1'b1);
    repeat (9) @(posedge clk);
    src0_inst.set_gate(1'b0);
    repeat (3) @(posedge clk);
    bus(1'b0, dtc_pkg::T0_COUNT_LOW_IDX, 8'h00);
    check({31'h0, rd >= 32'h19 && rd <= 32'h1b}, 32'h1, "gate open");
    bus(1'b1, dtc_pkg::CONFIG_IDX, 8'h00);
    repeat (10) @(posedge clk);
    bus(1'b0, dtc_pkg::T0_COUNT_LOW_IDX, 8'h00);
    check({31'h0, rd > 32'h1d}, 32'h1, "gate pin unused");
    bus(1'b1, dtc_pkg::CONFIG_IDX, 8'h02);
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h00);
    $display("test gate done");
  endtask
  // timer0 split in two; its high byte runs on timer1's run bit and flag
  task automatic t_split();
    bus(1'b1, dtc_pkg::TIMER_MODE_IDX, 8'h33);
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h40);
    period(1'b1, 256, "split high period");
    bus(1'b1, dtc_pkg::TIMER_CONTROL_IDX, 8'h00);
    rchk(dtc_pkg::T1_COUNT_LOW_IDX, 8'h09, "timer1 held");
    $display("test split done");
  endtask
  // reset, then every scenario in turn
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 12'h000;
    hwdata = 32'h0;
    ack0 = 1'b0;
    ack1 = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mode2();
    t_mode10();
    t_counter();
    t_gate();
    t_split();
    end_sim();
  end
endmodule
`default_nettype wire
